/* File: hdl/hmps_regs.sv */
// host address, serial prom access and memory self-test registers
// assumes an apb master on pclk and a self-test engine on the same clock;
// the prom data pin is asynchronous and passes two flip-flops first
`timescale 1ns/100ps
`default_nettype none

// Operation
// - after reset, load address from prom word 1
// - prom words 1,2,3 go to low, middle, high
// - software address writes never touch the prom
// - three 16-bit read/write address words
// - clock source bit resets to 0, 125MHz
// - divider field 00,01,10 divide by 1,2,3
// - drive strength bit resets low drive
// - access bit enables direct software pin control
// - write-only direction bit, 0 read 1 write
// - data pin level read without latching
// - bits 2..0 drive data, clock, select pins
// - tx self-test done bit set on completion
// - tx fail bit and fail count reported
// - rx done, fail and count reported
// - prom presence from data pin at reset
module hmps_regs #(
	parameter int unsigned HALF_CYC  = hmps_pkg::PROM_HALF_CYC,
	parameter int unsigned PADDR_W   = 8
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               prom_data_pin_i,
	output logic                    prom_data_pin_o,
	output logic                    prom_data_pin_oe,
	output logic                    prom_clock_pin,
	output logic                    prom_select_pin,
	output logic                    bus_clk_src_sel,
	output logic      [1:0]         bus_clk_ratio,
	output logic                    drive_strength_high,
	output logic                    prom_present,
	output logic                    irq,
	input  wire logic               tx_bist_done,
	input  wire logic               tx_bist_fail,
	input  wire logic [2:0]         tx_bist_fail_count,
	input  wire logic               rx_bist_done,
	input  wire logic               rx_bist_fail,
	input  wire logic [2:0]         rx_bist_fail_count
);

	// divider code to ratio; the reserved code falls back to divide by 1
	function automatic logic [1:0] div_ratio(input logic [1:0] code);
		div_ratio = (code == 2'h3) ? 2'h1 : code + 2'h1;
	endfunction : div_ratio

	// register index match on an aligned word address
	function automatic logic hit(input logic [PADDR_W-1:0] a,
		input logic [5:0] idx);
		hit = (a[1:0] == 2'h0) && (a[PADDR_W-1:2] == idx);
	endfunction : hit

	// apb handshake and decode
	logic               pready_q;        // one wait state, then ready
	logic [31:0]        prdata_q;        // captured read word
	logic               pslverr_q;       // unmapped address answer
	wire                acc_first = psel & penable & ~pready_q;
	wire                acc_done  = psel & penable & pready_q;
	wire                wr_done   = acc_done & pwrite;
	wire                sel_lo    = hit(paddr, hmps_pkg::IDX_ADDR_LO);
	wire                sel_mid   = hit(paddr, hmps_pkg::IDX_ADDR_MID);
	wire                sel_hi    = hit(paddr, hmps_pkg::IDX_ADDR_HI);
	wire                sel_bus   = hit(paddr, hmps_pkg::IDX_BUS_CTL);
	wire                sel_prom  = hit(paddr, hmps_pkg::IDX_PROM_CTL);
	wire                sel_test  = hit(paddr, hmps_pkg::IDX_SELFTEST);
	wire                sel_stat  = hit(paddr, hmps_pkg::IDX_IRQ_STAT);
	wire                sel_mask  = hit(paddr, hmps_pkg::IDX_IRQ_MASK);
	wire                sel_any   = sel_lo | sel_mid | sel_hi | sel_bus |
		sel_prom | sel_test | sel_stat | sel_mask;

	// register storage
	localparam int EV_N_W = hmps_pkg::EV_N;
	logic [15:0]        addr_lo_q;       // host address bytes 2,1
	logic [15:0]        addr_mid_q;      // host address bytes 4,3
	logic [15:0]        addr_hi_q;       // host address bytes 6,5
	logic [1:0]         bus_div_q;       // divider code
	logic               bus_src_q;       // source select, stored as written
	logic               drive_q;         // pad drive select
	logic [2:0]         sw_pins_q;       // software data, clock, select
	logic               sw_en_q;         // software access enable
	logic               sw_dir_q;        // software direction, write only
	logic [EV_N_W-1:0]  irq_stat_q;      // sticky events
	logic [EV_N_W-1:0]  irq_mask_q;      // event enables
	logic [1:0]         ratio_q;         // divide ratio output flop

	// self-test result holders
	logic               tx_done_q;
	logic               tx_fail_q;
	logic [2:0]         tx_cnt_q;
	logic               rx_done_q;
	logic               rx_fail_q;
	logic [2:0]         rx_cnt_q;

	// data pin synchroniser; only din_q2 is read by logic
	logic               din_q1;
	logic               din_q2;

	// prom load engine
	hmps_pkg::hmps_state_t state_q;
	logic               present_q;       // strap caught after reset
	logic [1:0]         settle_q;        // strap settle counter
	logic [1:0]         slot_q;          // address word slot 1..3
	logic [4:0]         bit_q;           // bit within a read frame
	logic               phase_q;         // clock pin phase, 1 = high
	logic [15:0]        half_q;          // cycles left in this half
	logic [8:0]         cmd_q;           // command bits shifting out
	logic [15:0]        shin_q;          // data bits shifting in

	// pin and misc output flops
	logic               pin_do_q;
	logic               pin_oe_q;
	logic               pin_sk_q;
	logic               pin_cs_q;
	logic               irq_q;

	// load engine step conditions
	wire                half_end  = (half_q == 16'h0000);
	wire                bit_end   = (state_q == hmps_pkg::ST_SHIFT) &
		half_end & phase_q;
	wire                frame_end = bit_end & (bit_q == hmps_pkg::PROM_LAST_BIT);
	wire                word_in   = bit_end & (bit_q >= hmps_pkg::PROM_CMD_BITS);
	wire [15:0]         word_val  = {shin_q[14:0], din_q2};
	wire                load_busy = (state_q != hmps_pkg::ST_DONE);
	wire                store_lo  = frame_end & (slot_q == 2'h1);
	wire                store_mid = frame_end & (slot_q == 2'h2);
	wire                store_hi  = frame_end & (slot_q == 2'h3);
	wire [15:0]         half_rst  = 16'(HALF_CYC - 1);

	// pin ownership: engine while loading, then software when enabled
	wire                eng_on    = (state_q == hmps_pkg::ST_SHIFT);
	wire                sw_on     = ~load_busy & sw_en_q;
	wire                do_d      = eng_on ? cmd_q[8] :
		(sw_on & sw_pins_q[hmps_pkg::PROM_DO_BIT]);
	wire                oe_d      = eng_on ? (bit_q < hmps_pkg::PROM_CMD_BITS) :
		(sw_on & sw_dir_q);
	wire                sk_d      = eng_on ? phase_q :
		(sw_on & sw_pins_q[hmps_pkg::PROM_SK_BIT]);
	wire                cs_d      = eng_on |
		(sw_on & sw_pins_q[hmps_pkg::PROM_CS_BIT]);

	// self-test events, seen as the rise of each held done flag
	wire                tx_ev     = tx_bist_done & ~tx_done_q;
	wire                rx_ev     = rx_bist_done & ~rx_done_q;
	wire                fail_ev   = (tx_ev & tx_bist_fail) | (rx_ev & rx_bist_fail);
	wire [EV_N_W-1:0]   ev_set    = {fail_ev, rx_ev, tx_ev, store_hi};
	wire [EV_N_W-1:0]   ev_clr    = (wr_done & sel_stat) ?
		pwdata[EV_N_W-1:0] : '0;
	wire [EV_N_W-1:0]   stat_d    = ev_set | (irq_stat_q & ~ev_clr);

	// read words; reserved and write-only bits read zero
	wire [15:0]         rd_bus    = {9'h000, drive_q, 3'h0, bus_src_q, bus_div_q};
	wire [15:0]         rd_prom   = {10'h000, 1'b0, sw_en_q, din_q2, sw_pins_q};
	wire [15:0]         rd_test   = {3'h0, tx_done_q, tx_fail_q, tx_cnt_q,
		3'h0, rx_done_q, rx_fail_q, rx_cnt_q};
	wire [15:0]         rd_word   =
		sel_lo   ? addr_lo_q  :
		sel_mid  ? addr_mid_q :
		sel_hi   ? addr_hi_q  :
		sel_bus  ? rd_bus     :
		sel_prom ? rd_prom    :
		sel_test ? rd_test    :
		sel_stat ? {12'h000, irq_stat_q} :
		sel_mask ? {12'h000, irq_mask_q} : 16'h0000;

	// apb answer: ready one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= acc_first;
			pslverr_q <= acc_first & ~sel_any;
			// read data captured before ready so it comes from a flop
			if (acc_first & ~pwrite) begin
				prdata_q <= {16'h0000, rd_word};
			end
		end
	end

	// host address words: prom load and software writes, prom never written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_lo_q  <= hmps_pkg::ADDR_WORD_RST;
			addr_mid_q <= hmps_pkg::ADDR_WORD_RST;
			addr_hi_q  <= hmps_pkg::ADDR_WORD_RST;
		end else begin
			if (store_lo) begin
				addr_lo_q <= word_val;
			end else if (wr_done & sel_lo) begin
				addr_lo_q <= pwdata[15:0];
			end
			if (store_mid) begin
				addr_mid_q <= word_val;
			end else if (wr_done & sel_mid) begin
				addr_mid_q <= pwdata[15:0];
			end
			if (store_hi) begin
				addr_hi_q <= word_val;
			end else if (wr_done & sel_hi) begin
				addr_hi_q <= pwdata[15:0];
			end
		end
	end

	// bus clock and drive control; reserved bits are not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_div_q <= hmps_pkg::BUS_DIV_RST;
			bus_src_q <= 1'b0;
			drive_q   <= 1'b0;
		end else if (wr_done & sel_bus) begin
			bus_div_q <= pwdata[hmps_pkg::BUS_DIV_LSB +: 2];
			bus_src_q <= pwdata[hmps_pkg::BUS_SRC_BIT];
			drive_q   <= pwdata[hmps_pkg::BUS_DRIVE_BIT];
		end
	end

	// software prom control bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_pins_q <= hmps_pkg::PROM_PINS_RST;
			sw_en_q   <= 1'b0;
			sw_dir_q  <= 1'b0;
		end else if (wr_done & sel_prom) begin
			sw_pins_q <= pwdata[2:0];
			sw_en_q   <= pwdata[hmps_pkg::PROM_EN_BIT];
			sw_dir_q  <= pwdata[hmps_pkg::PROM_DIR_BIT];
		end
	end

	// self-test results held until the next reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_done_q <= 1'b0;
			tx_fail_q <= 1'b0;
			tx_cnt_q  <= 3'h0;
			rx_done_q <= 1'b0;
			rx_fail_q <= 1'b0;
			rx_cnt_q  <= 3'h0;
		end else begin
			// fail and count only follow the done flag, so they read zero before
			if (tx_ev) begin
				tx_done_q <= 1'b1;
				tx_fail_q <= tx_bist_fail;
				tx_cnt_q  <= tx_bist_fail_count;
			end
			if (rx_ev) begin
				rx_done_q <= 1'b1;
				rx_fail_q <= rx_bist_fail;
				rx_cnt_q  <= rx_bist_fail_count;
			end
		end
	end

	// interrupt status and mask; a new event beats a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			irq_q      <= 1'b0;
		end else begin
			irq_stat_q <= stat_d;
			if (wr_done & sel_mask) begin
				irq_mask_q <= pwdata[EV_N_W-1:0];
			end
			irq_q <= |(stat_d & irq_mask_q);
		end
	end

	// two-flop synchroniser on the prom data pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_q1 <= 1'b0;
			din_q2 <= 1'b0;
		end else begin
			din_q1 <= prom_data_pin_i;
			din_q2 <= din_q1;
		end
	end

	// load engine: strap wait, then three read frames if a prom is present, then idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= hmps_pkg::ST_STRAP;
			present_q <= 1'b0;
			settle_q  <= 2'h0;
			slot_q    <= 2'h1;
			bit_q     <= 5'h00;
			phase_q   <= 1'b0;
			half_q    <= 16'h0000;
			cmd_q     <= 9'h000;
			shin_q    <= 16'h0000;
		end else begin
			case (state_q)
				hmps_pkg::ST_STRAP: begin
					// the pin is undriven here, so its pull shows presence
					settle_q <= settle_q + 2'h1;
					if (settle_q == hmps_pkg::STRAP_SETTLE) begin
						present_q <= din_q2;
						state_q   <= din_q2 ? hmps_pkg::ST_GAP :
							hmps_pkg::ST_DONE;
					end
				end
				hmps_pkg::ST_GAP: begin
					// select low for one half period between frames
					if (half_end) begin
						state_q <= hmps_pkg::ST_SHIFT;
						half_q  <= half_rst;
						bit_q   <= 5'h00;
						phase_q <= 1'b0;
						cmd_q   <= {hmps_pkg::PROM_READ_OP,
							hmps_pkg::PROM_FIRST_WORD + 6'(slot_q) - 6'h01};
					end else begin
						half_q <= half_q - 16'h0001;
					end
				end
				hmps_pkg::ST_SHIFT: begin
					if (!half_end) begin
						half_q <= half_q - 16'h0001;
					end else begin
						half_q  <= half_rst;
						phase_q <= ~phase_q;
						if (phase_q) begin
							// bit finishes at the falling edge of the clock pin
							bit_q <= bit_q + 5'h01;
							cmd_q <= {cmd_q[7:0], 1'b0};
							if (word_in) begin
								shin_q <= word_val;
							end
							if (frame_end) begin
								slot_q  <= slot_q + 2'h1;
								state_q <= (slot_q == hmps_pkg::PROM_LAST_SLOT) ?
									hmps_pkg::ST_DONE : hmps_pkg::ST_GAP;
							end
						end
					end
				end
				default: begin
					state_q <= hmps_pkg::ST_DONE;
				end
			endcase
		end
	end

	// registered prom pins: data, enable, clock and select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_do_q <= 1'b0;
			pin_oe_q <= 1'b0;
			pin_sk_q <= 1'b0;
			pin_cs_q <= 1'b0;
		end else begin
			pin_do_q <= do_d;
			pin_oe_q <= oe_d;
			pin_sk_q <= sk_d;
			pin_cs_q <= cs_d;
		end
	end

	// outputs: each comes from a flop except bus_clk_src_sel, tied to 0
	assign prdata              = prdata_q;
	assign pready              = pready_q;
	assign pslverr             = pslverr_q;
	assign prom_data_pin_o     = pin_do_q;
	assign prom_data_pin_oe    = pin_oe_q;
	assign prom_clock_pin      = pin_sk_q;
	assign prom_select_pin     = pin_cs_q;
	// only the 125MHz source exists, so the reserved select never leaves
	assign bus_clk_src_sel     = 1'b0;
	assign drive_strength_high = drive_q;
	assign prom_present        = present_q;
	assign irq                 = irq_q;
	assign bus_clk_ratio       = ratio_q;

	// divide ratio kept in a flop so the output is registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ratio_q <= 2'h1;
		end else begin
			ratio_q <= div_ratio(bus_div_q);
		end
	end

endmodule : hmps_regs

`default_nettype wire

/* File: hdl/hmps_pkg.sv */
// package of the host address, serial prom and self-test register group
// assumes a 40 MHz pclk and an apb master with 32-bit data
package hmps_pkg;

	// register indices; the apb byte address is four times the index
	localparam logic [5:0] IDX_ADDR_LO  = 6'h10; // host_address_low_word
	localparam logic [5:0] IDX_ADDR_MID = 6'h12; // host_address_middle_word
	localparam logic [5:0] IDX_ADDR_HI  = 6'h14; // host_address_high_word
	localparam logic [5:0] IDX_BUS_CTL  = 6'h20; // bus_clock_and_drive_control
	localparam logic [5:0] IDX_PROM_CTL = 6'h22; // serial_prom_control
	localparam logic [5:0] IDX_SELFTEST = 6'h24; // memory_selftest_info
	localparam logic [5:0] IDX_IRQ_STAT = 6'h30; // sticky event status, w1c
	localparam logic [5:0] IDX_IRQ_MASK = 6'h32; // event enable mask

	// bus_clock_and_drive_control fields
	localparam int BUS_DIV_LSB   = 0; // two-bit divider field
	localparam int BUS_SRC_BIT   = 2; // clock source select
	localparam int BUS_DRIVE_BIT = 6; // pad drive strength
	localparam logic [1:0] BUS_DIV_RST = 2'h0;

	// serial_prom_control fields
	localparam int PROM_CS_BIT  = 0; // select pin control
	localparam int PROM_SK_BIT  = 1; // clock pin control
	localparam int PROM_DO_BIT  = 2; // data out control
	localparam int PROM_DI_BIT  = 3; // data pin level
	localparam int PROM_EN_BIT  = 4; // software access enable
	localparam int PROM_DIR_BIT = 5; // software direction
	localparam logic [2:0] PROM_PINS_RST = 3'h0;

	// memory_selftest_info fields
	localparam int TX_CNT_LSB   = 8;
	localparam int TX_FAIL_BIT  = 11;
	localparam int TX_DONE_BIT  = 12;
	localparam int RX_CNT_LSB   = 0;
	localparam int RX_FAIL_BIT  = 3;
	localparam int RX_DONE_BIT  = 4;

	// interrupt status bits
	localparam int EV_LOAD = 0; // address load from prom finished
	localparam int EV_TX   = 1; // tx self-test finished
	localparam int EV_RX   = 2; // rx self-test finished
	localparam int EV_FAIL = 3; // any self-test failed
	localparam int EV_N    = 4;

	// prom read sequence
	localparam logic [5:0] PROM_FIRST_WORD = 6'h01;
	localparam logic [1:0] PROM_LAST_SLOT  = 2'h3;
	localparam logic [2:0] PROM_READ_OP    = 3'h6; // start bit + read op
	localparam logic [4:0] PROM_CMD_BITS   = 5'h09;
	localparam logic [4:0] PROM_LAST_BIT   = 5'h18; // 9 command + 16 data
	localparam int PROM_HALF_NS = 1000; // least half period of the clock
	localparam int PCLK_NS      = 25;
	localparam int PROM_HALF_CYC = (PROM_HALF_NS + PCLK_NS - 1) / PCLK_NS;
	localparam logic [1:0] STRAP_SETTLE = 2'h3; // cycles before strap latch

	localparam logic [15:0] ADDR_WORD_RST = 16'h0000;

	typedef enum logic [1:0] {
		ST_STRAP,
		ST_GAP,
		ST_SHIFT,
		ST_DONE
	} hmps_state_t;

endpackage : hmps_pkg

/* File: test/hmps_prom_model.sv */
// serial prom model standing on the device's prom pins
// assumes the bench resolves the data line from every party's enable
`timescale 1ns/100ps
`default_nettype none
module hmps_prom_model (
	input  wire logic prom_select_pin, // chip select from the device
	input  wire logic prom_clock_pin,  // serial clock from the device
	input  wire logic line,            // resolved data line level
	output var  logic drv,             // model drives the line
	output var  logic val,             // level it drives
	output var  int   frames           // frames opened by select
);
	int          n;   // clock rises in the open frame
	logic [8:0]  cmd; // start bit, opcode, word address
	logic [15:0] w;   // word being shifted out
	// stored words; only 1..3 carry the host address
	function automatic logic [15:0] word(input logic [5:0] a);
		case (a)
			6'h01: return 16'h89AB;
			6'h02: return 16'h4567;
			6'h03: return 16'h0123;
			default: return {10'h2A5, a};
		endcase
	endfunction : word
	initial begin
		n = 0;
		drv = 1'b0;
		val = 1'b0;
		frames = 0;
	end
	// count frames so the bench sees any unwanted prom traffic
	always @(posedge prom_select_pin) frames = frames + 1;
	// deselect releases the line, which then falls to its pull level
	always @(negedge prom_select_pin) begin
		n = 0;
		drv = 1'b0;
	end
	// command in on rises 1..9, data out msb first on rises 10..25
	always @(posedge prom_clock_pin) begin
		if (prom_select_pin) begin
			n = n + 1;
			if (n <= 9) cmd = {cmd[7:0], line};
			if (n >= 10 && n <= 25 && cmd[8:6] == 3'b110) begin
				w = word(cmd[5:0]);
				drv = 1'b1;
				val = w[25-n];
			end else begin
				drv = 1'b0; // hold over: let the pull take the line
			end
		end
	end
endmodule : hmps_prom_model
`default_nettype wire

/* File: test/hmps_regs_asserts.sv */
// port checker of the host address, prom and self-test registers
// assumes apb byte addresses are four times the register index
`timescale 1ns/100ps
`default_nettype none
module hmps_regs_asserts #(
	parameter int unsigned HALF_CYC = 2,
	parameter int unsigned PADDR_W  = 8
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               bus_clk_src_sel,
	input wire logic [1:0]         bus_clk_ratio,
	input wire logic               drive_strength_high,
	input wire logic               prom_present,
	input wire logic               irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic ack   = psel && penable && pready; // answering edge
	wire logic wr_bc = ack && pwrite && paddr == 8'h80; // bus ctl write
	wire logic rd    = ack && !pwrite; // any read answer
	logic [1:0] exp_ratio_q; // divider the last write asked for
	logic       exp_drv_q;   // drive the last write asked for
	logic [3:0] cyc_q;       // cycles since reset, saturating
	// expected divider and drive, captured at the write edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exp_ratio_q <= 2'h1;
			exp_drv_q   <= 1'b0;
		end else if (wr_bc) begin
			exp_ratio_q <= (pwdata[1:0] == 2'h2) ? 2'h3 :
				(pwdata[1:0] == 2'h1) ? 2'h2 : 2'h1;
			exp_drv_q   <= pwdata[6];
		end
	end
	// the strap is long settled once this saturates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cyc_q <= 4'h0;
		else if (cyc_q != 4'hF) cyc_q <= cyc_q + 4'h1;
	end
	AST_ONE_WAIT: assert property (
		(psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	AST_ERR_READY: assert property (
		pslverr |-> pready && (pwrite || prdata == 32'h0000_0000))
		else $error("error answer without ready or with data");
	AST_UPPER_ZERO: assert property (
		rd |-> prdata[31:16] == 16'h0000)
		else $error("read data above bit 15 not zero");
	AST_SRC_ZERO: assert property (
		!bus_clk_src_sel)
		else $error("clock source left the only legal source");
	AST_RATIO: assert property (
		wr_bc |-> ##[1:3] bus_clk_ratio == exp_ratio_q)
		else $error("divider does not follow the written code");
	AST_DRIVE: assert property (
		wr_bc |-> ##[1:3] drive_strength_high == exp_drv_q)
		else $error("drive strength does not follow the write");
	AST_STRAP_HELD: assert property (
		cyc_q == 4'hF |-> $stable(prom_present))
		else $error("prom presence changed after the strap latch");
	AST_SELFTEST_ZERO: assert property (
		rd && paddr == 8'h90 |-> prdata[15:13] == 3'h0 &&
		prdata[7:5] == 3'h0 && (prdata[12] || prdata[11:8] == 4'h0) &&
		(prdata[4] || prdata[3:0] == 4'h0))
		else $error("self-test fields not zero before done");
	AST_PROMCTL_WO: assert property (
		rd && paddr == 8'h88 |-> prdata[31:5] == 27'h0)
		else $error("prom control reads back write-only bits");
	cover property (wr_bc && pwdata[1:0] == 2'h2);
	cover property (rd && paddr == 8'h90 && prdata[12]);
	cover property (ack && pslverr);
	cover property ($rose(irq));
endmodule : hmps_regs_asserts
bind hmps_regs hmps_regs_asserts #(.HALF_CYC(HALF_CYC), .PADDR_W(PADDR_W))
	u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .bus_clk_src_sel(bus_clk_src_sel),
	.bus_clk_ratio(bus_clk_ratio), .drive_strength_high(drive_strength_high),
	.prom_present(prom_present), .irq(irq));
`default_nettype wire

/* File: test/hmps_regs_tb.sv */
// self-checking bench of the host address, prom and self-test registers
// assumes the prom model on the pins and a pull on the data line
`timescale 1ns/100ps
`default_nettype none
module hmps_regs_tb;
	typedef struct packed {
		logic [7:0]  a; // byte address
		logic        w; // write when set
		logic [31:0] d; // write data
		logic [31:0] x; // expected read data
		logic        e; // expected error
	} hmps_row_t;
	logic        pclk = 1'b0, presetn = 1'b0, pull_lvl = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, mdl_drv, mdl_val, line;
	logic        pin_o, pin_oe, sk, cs, src, drv_hi, present, irq;
	logic [1:0]  ratio;
	logic        txd = 1'b0, txf = 1'b1, rxd = 1'b0, rxf = 1'b1;
	logic [2:0]  txc = 3'h7, rxc = 3'h3; // junk before done
	int          frames, failures = 0, check_count = 0, n, i;
	// ordinary accesses after the hardware load
	hmps_row_t rows [15] = '{
		'{8'h40, 1'b0, 32'h0, 32'h89AB, 1'b0},
		'{8'h48, 1'b0, 32'h0, 32'h4567, 1'b0},
		'{8'h50, 1'b0, 32'h0, 32'h0123, 1'b0},
		'{8'h80, 1'b0, 32'h0, 32'h0000, 1'b0},
		'{8'h88, 1'b0, 32'h0, 32'h0008, 1'b0},
		'{8'h90, 1'b0, 32'h0, 32'h0000, 1'b0},
		'{8'h40, 1'b1, 32'hFFFF1234, 32'h0, 1'b0},
		'{8'h40, 1'b0, 32'h0, 32'h1234, 1'b0},
		'{8'h50, 1'b1, 32'hA5A5, 32'h0, 1'b0},
		'{8'h50, 1'b0, 32'h0, 32'hA5A5, 1'b0},
		'{8'h80, 1'b1, 32'hFFFF, 32'h0, 1'b0},
		'{8'h80, 1'b0, 32'h0, 32'h0047, 1'b0},
		'{8'h3C, 1'b0, 32'h0, 32'h0000, 1'b1},
		'{8'h41, 1'b1, 32'h0, 32'h0000, 1'b1},
		'{8'h44, 1'b0, 32'h0, 32'h0000, 1'b1}};
	logic [31:0] bc_exp [4] = '{32'h5, 32'h9, 32'hD, 32'h5}; // ratio,src,drv
	// whoever drives wins, else the pull holds the line
	assign line = pin_oe ? pin_o : (mdl_drv ? mdl_val : pull_lvl);
	always #12.5 pclk = ~pclk;
	// four cycles a half: pin flop and synchroniser lag the sample by three
	hmps_regs #(.HALF_CYC(4), .PADDR_W(8)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prom_data_pin_i(line), .prom_data_pin_o(pin_o),
		.prom_data_pin_oe(pin_oe), .prom_clock_pin(sk),
		.prom_select_pin(cs), .bus_clk_src_sel(src), .bus_clk_ratio(ratio),
		.drive_strength_high(drv_hi), .prom_present(present), .irq(irq),
		.tx_bist_done(txd), .tx_bist_fail(txf), .tx_bist_fail_count(txc),
		.rx_bist_done(rxd), .rx_bist_fail(rxf), .rx_bist_fail_count(rxc));
	hmps_prom_model u_prom (.prom_select_pin(cs), .prom_clock_pin(sk),
		.line(line), .drv(mdl_drv), .val(mdl_val), .frames(frames));
	// one apb transfer, held until ready is seen, then released
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 40);
		// data and error are taken at the very edge that sees ready
		rd  = prdata;
		err = pslverr;
		if (k >= 40) failures++;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic settle(input int k);
		repeat (k) @(posedge pclk);
	endtask : settle
	task automatic do_reset(input logic lvl);
		@(posedge pclk);
		pull_lvl <= lvl; // strap level must be steady before release
		presetn  <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn  <= 1'b1;
	endtask : do_reset
	task automatic stop_test;
		$display("mismatches %0d in %0d checks", failures, check_count);
		if (failures == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test
	// a hang costs a mismatch and ends the run the normal way
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		stop_test();
	end
	initial begin
		do_reset(1'b1);
		settle(1);
		chk({28'h0, ratio, src, drv_hi}, 32'h4);
		n = 0;
		do begin
			xfer(8'hC0, 1'b0, 32'h0); // poll the load-done event
			n++;
		end while (rd[0] !== 1'b1 && n < 400);
		chk(frames, 32'h3);
		chk({31'h0, present}, 32'h1);
		for (i = 0; i < 15; i++) begin
			xfer(rows[i].a, rows[i].w, rows[i].d);
			if (!rows[i].w) chk(rd, rows[i].x);
			chk({31'h0, err}, {31'h0, rows[i].e});
		end
		chk(frames, 32'h3);
		for (i = 0; i < 4; i++) begin
			xfer(8'h80, 1'b1, 32'h44 | i);
			settle(3);
			chk({28'h0, ratio, src, drv_hi}, bc_exp[i]);
		end
		xfer(8'h88, 1'b1, 32'h07); // pin bits with access off
		settle(3);
		chk({29'h0, pin_oe, sk, cs}, 32'h0);
		xfer(8'h88, 1'b1, 32'h35); // write mode, data and select high
		settle(3);
		chk({28'h0, pin_oe, pin_o, sk, cs}, 32'hD);
		pull_lvl <= 1'b0;
		xfer(8'h88, 1'b1, 32'h12); // read mode, clock high
		settle(3);
		chk({29'h0, pin_oe, sk, cs}, 32'h2);
		xfer(8'h88, 1'b0, 32'h0);
		chk(rd, 32'h12);
		pull_lvl <= 1'b1;
		settle(3);
		xfer(8'h88, 1'b0, 32'h0);
		chk(rd, 32'h1A);
		xfer(8'hC8, 1'b1, 32'h0);
		xfer(8'hC0, 1'b1, 32'hF);
		txc <= 3'h5;
		rxc <= 3'h2;
		txd <= 1'b1;
		rxd <= 1'b1;
		settle(2);
		txc <= 3'h0; // late change must not reach the register
		settle(2);
		chk({31'h0, irq}, 32'h0);
		xfer(8'h90, 1'b0, 32'h0);
		chk(rd, 32'h1D1A);
		xfer(8'hC0, 1'b0, 32'h0);
		chk(rd, 32'hE);
		xfer(8'hC8, 1'b1, 32'h4);
		settle(2);
		chk({31'h0, irq}, 32'h1);
		xfer(8'hC0, 1'b1, 32'h4);
		settle(2);
		chk({31'h0, irq}, 32'h0);
		do_reset(1'b0); // no prom fitted this time
		settle(500);
		chk({31'h0, present}, 32'h0);
		chk(frames, 32'h4);
		xfer(8'h48, 1'b0, 32'h0);
		chk(rd, 32'h0);
		xfer(8'h48, 1'b1, 32'hBEEF);
		xfer(8'h48, 1'b0, 32'h0);
		chk(rd, 32'hBEEF);
		stop_test();
	end
endmodule : hmps_regs_tb
`default_nettype wire
